// ===== rtl/pmu_mode_pkg.sv
// constants shared by the mode control block and its voltage ramp
package pmu_mode_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_BUCK = 3;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ENABLE = 8'h01;
  localparam logic [7:0] REG_BUCK_CFG = 8'h02;
  localparam logic [7:0] REG_VSET_CORE = 8'h03;
  localparam logic [7:0] REG_VSET_IO = 8'h04;
  localparam logic [7:0] REG_VSET_MEM = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_REPEAT_WR = 0;
  localparam int CTRL_MEM_STANDBY_REQUEST_PIN_KEEP = 1;
  localparam int CTRL_ANALOG_CORE_REGULATOR_STANDBY_REQUEST_PIN_ON = 2;
  localparam int CTRL_VSTEP_COARSE = 3;
  localparam int EN_CORE = 0;
  localparam int EN_IO = 1;
  localparam int EN_ANALOG_CORE_REGULATOR = 2;
  localparam int EN_EMMC_REGULATOR = 3;
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_PD_LO = 2;
  localparam int ST_STANDBY_BIT = 0;
  localparam int ST_RAMP_LO = 1;
  localparam int ST_TWO_PHASE = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [7:0] ENABLE_RST = 8'h0d;
  localparam logic [7:0] BUCK_CFG_RST = 8'h02;
  // codes at the default 12.5 mv step: 1.0 v and 1.5 v
  localparam logic [7:0] VSET_IO_RST = 8'h50;
  localparam logic [7:0] VSET_MEM_RST = 8'h78;
  localparam logic [7:0] VSET_CORE_RST = 8'h50;

  // ---------------------------------------------------------------
  // memory buck operating modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_PWM = 2'h0;
  localparam logic [1:0] MODE_PFM = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h1;

  // ---------------------------------------------------------------
  // sequencing order and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] RANK_NONE = 3'h0;
  localparam logic [2:0] RANK_CORE = 3'h1;
  localparam logic [2:0] RANK_IO = 3'h2;
  localparam logic [2:0] RANK_MEM = 3'h3;
  localparam logic [2:0] RANK_ANALOG_CORE_REGULATOR = 3'h4;
  localparam logic [2:0] RANK_EMMC_REGULATOR = 3'h5;
  localparam int CLK_MHZ = 200;
  localparam int SEQ_STEP_NS = 128000;
  localparam int SEQ_STEP_CYC = SEQ_STEP_NS * CLK_MHZ / 1000;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYC = RAMP_STEP_NS * CLK_MHZ / 1000;

  // ---------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2c; // arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : pmu_mode_pkg

// ===== rtl/volt_ramp.sv
// moves a voltage code one step at a time toward its target
`timescale 1ns/10ps
`default_nettype none

module volt_ramp #(
  parameter int W = 8,
  parameter int STEP_CYC = 200,
  parameter logic [7:0] INIT = 8'h00
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // target and ramped output
  input wire logic [W-1:0] i_target,
  output logic [W-1:0] o_level,
  output logic o_busy
);

  logic [15:0] cnt_q;
  logic [W-1:0] level_q;
  logic busy_q;

  // ---------------------------------------------------------------
  // step timer
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst || level_q == i_target || cnt_q == 16'(STEP_CYC - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // one code per step toward the target
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      level_q <= INIT[W-1:0];
    end else if (cnt_q == 16'(STEP_CYC - 1)) begin
      if (level_q < i_target) begin
        level_q <= level_q + W'(1);
      end else if (level_q > i_target) begin
        level_q <= level_q - W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (level_q != i_target);
    end
  end

  assign o_level = level_q;
  assign o_busy = busy_q;

endmodule : volt_ramp

`default_nettype wire

// ===== rtl/pmu_mode_control.sv
// regulator enable, mode and voltage control with serial register writes
`timescale 1ns/10ps
`default_nettype none

module pmu_mode_control
  import pmu_mode_pkg::*;
#(
  parameter int SEQ_STEP = pmu_mode_pkg::SEQ_STEP_CYC,
  parameter int RAMP_STEP = pmu_mode_pkg::RAMP_STEP_CYC,
  parameter logic [6:0] SLAVE_ADDR = pmu_mode_pkg::SLAVE_ADDR_DEF
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // register port
  input wire logic [pmu_mode_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pmu_mode_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pmu_mode_pkg::DATA_W-1:0] o_rd_data,
  // serial bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // otp settings
  input wire logic [7:0] i_otp_core_vset,
  input wire logic i_otp_two_phase,
  input wire logic i_otp_mem_standby_request_pin_keep,
  // standby request pin
  input wire logic i_standby_request_pin,
  // regulator controls
  output logic o_core_buck_en,
  output logic o_io_buck_en,
  output logic o_memory_buck_en,
  output logic o_analog_core_regulator_en,
  output logic o_emmc_regulator_en,
  output logic [1:0] o_memory_buck_mode,
  output logic o_core_two_phase,
  output logic [pmu_mode_pkg::NUM_BUCK-1:0] o_pulldown_en,
  output logic o_analog_core_regulator_from_emmc_regulator_supply_input,
  output logic o_analog_core_regulator_supply_input_stage_en,
  output logic o_vset_step_coarse,
  output logic [pmu_mode_pkg::NUM_BUCK-1:0][7:0] o_buck_voltage_setting,
  output logic o_standby
);
  import pmu_mode_pkg::*;

  typedef enum logic [1:0] {PW_UP, PW_NORMAL, PW_DOWN, PW_STANDBY} pwr_state_e;
  typedef enum logic [1:0] {SI_IDLE, SI_DEV, SI_REG, SI_DATA} ser_state_e;

  logic [7:0] ctrl_q, enable_q, buck_cfg_q;
  logic [NUM_BUCK-1:0][7:0] vset_q;
  logic [NUM_BUCK-1:0] ramp_busy;
  logic otp_load_q, two_phase_q;
  logic standby_request_pin_meta_q, standby_request_pin_sync_q;
  pwr_state_e pwr_q;
  logic [2:0] seq_q;
  logic [31:0] seq_cnt_q;
  logic seq_tick;
  logic scl_q, sda_q;
  logic start_det, stop_det, scl_rise, scl_fall;
  ser_state_e ser_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q, reg_ptr_q;
  logic ack_q, sda_oe_q, sda_out_q;
  logic ser_wr_q;
  logic [7:0] ser_wr_addr_q, ser_wr_data_q;
  logic wr_en;
  logic [7:0] wr_addr, wr_data;
  logic [7:0] rd_data_q;
  logic low_side, core_en_d, io_en_d, mem_en_d;

  // ---------------------------------------------------------------
  // standby pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      standby_request_pin_meta_q <= 1'b0;
      standby_request_pin_sync_q <= 1'b0;
    end else begin
      standby_request_pin_meta_q <= i_standby_request_pin;
      standby_request_pin_sync_q <= standby_request_pin_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // serial slave: edge and condition detection
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  assign start_det = scl_q && i_scl && sda_q && !i_sda;
  assign stop_det = scl_q && i_scl && !sda_q && i_sda;
  assign scl_rise = !scl_q && i_scl;
  assign scl_fall = scl_q && !i_scl;

  // ---------------------------------------------------------------
  // serial slave: byte engine, runs in every power state
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ser_q <= SI_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      reg_ptr_q <= 8'h00;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ser_wr_q <= 1'b0;
      ser_wr_addr_q <= 8'h00;
      ser_wr_data_q <= 8'h00;
    end else begin
      ser_wr_q <= 1'b0;
      if (stop_det) begin
        ser_q <= SI_IDLE;
        ack_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (start_det) begin
        // whatever was under way is dropped; the new start opens a fresh message
        ser_q <= SI_DEV;
        bit_q <= 4'h0;
        ack_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (ser_q != SI_IDLE) begin
        if (scl_rise && !ack_q) begin
          shift_q <= {shift_q[6:0], i_sda};
          bit_q <= bit_q + 4'h1;
        end else if (scl_fall && ack_q) begin
          ack_q <= 1'b0;
          sda_oe_q <= 1'b0;
          unique case (ser_q)
            SI_DEV: ser_q <= SI_REG;
            SI_REG: ser_q <= SI_DATA;
            SI_DATA: ser_q <= ctrl_q[CTRL_REPEAT_WR] ? SI_REG : SI_DATA;
            default: ser_q <= SI_IDLE;
          endcase
        end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
          bit_q <= 4'h0;
          unique case (ser_q)
            SI_DEV: begin
              if (shift_q[7:1] == SLAVE_ADDR && !shift_q[0]) begin
                ack_q <= 1'b1;
                sda_oe_q <= 1'b1;
              end else begin
                ser_q <= SI_IDLE;
              end
            end
            SI_REG: begin
              reg_ptr_q <= shift_q;
              ack_q <= 1'b1;
              sda_oe_q <= 1'b1;
            end
            SI_DATA: begin
              ser_wr_q <= 1'b1;
              ser_wr_addr_q <= reg_ptr_q;
              ser_wr_data_q <= shift_q;
              // page mode steps the pointer, repeated mode reloads it
              reg_ptr_q <= reg_ptr_q + 8'h01;
              ack_q <= 1'b1;
              sda_oe_q <= 1'b1;
            end
            default: ser_q <= SI_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sda_out_q <= 1'b1;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write merge: a serial write wins over a port write in one cycle
  // ---------------------------------------------------------------
  assign wr_en = ser_wr_q || i_wr;
  assign wr_addr = ser_wr_q ? ser_wr_addr_q : i_addr;
  assign wr_data = ser_wr_q ? ser_wr_data_q : i_wr_data;

  // ---------------------------------------------------------------
  // otp capture one cycle after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      otp_load_q <= 1'b1;
      two_phase_q <= 1'b0;
    end else begin
      otp_load_q <= 1'b0;
      if (otp_load_q) begin
        two_phase_q <= i_otp_two_phase;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl_q <= CTRL_RST;
    end else if (otp_load_q) begin
      ctrl_q[CTRL_MEM_STANDBY_REQUEST_PIN_KEEP] <= i_otp_mem_standby_request_pin_keep;
    end else if (wr_en && wr_addr == REG_CTRL) begin
      ctrl_q <= wr_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      enable_q <= ENABLE_RST;
    end else if (wr_en && wr_addr == REG_ENABLE) begin
      enable_q <= wr_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      buck_cfg_q <= BUCK_CFG_RST;
    end else if (wr_en && wr_addr == REG_BUCK_CFG) begin
      buck_cfg_q <= wr_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      vset_q[0] <= VSET_CORE_RST;
      vset_q[1] <= VSET_IO_RST;
      vset_q[2] <= VSET_MEM_RST;
    end else if (otp_load_q) begin
      vset_q[0] <= i_otp_core_vset;
    end else if (wr_en && wr_addr == REG_VSET_CORE) begin
      vset_q[0] <= wr_data;
    end else if (wr_en && wr_addr == REG_VSET_IO) begin
      vset_q[1] <= wr_data;
    end else if (wr_en && wr_addr == REG_VSET_MEM) begin
      vset_q[2] <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // read port: data stand only in the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst || !i_rd) begin
      rd_data_q <= 8'h00;
    end else begin
      unique case (i_addr)
        REG_CTRL: rd_data_q <= ctrl_q;
        REG_ENABLE: rd_data_q <= enable_q;
        REG_BUCK_CFG: rd_data_q <= buck_cfg_q;
        REG_VSET_CORE: rd_data_q <= vset_q[0];
        REG_VSET_IO: rd_data_q <= vset_q[1];
        REG_VSET_MEM: rd_data_q <= vset_q[2];
        REG_STATUS: begin
          rd_data_q <= 8'h00;
          rd_data_q[ST_STANDBY_BIT] <= (pwr_q == PW_STANDBY);
          rd_data_q[ST_RAMP_LO +: NUM_BUCK] <= ramp_busy;
          rd_data_q[ST_TWO_PHASE] <= two_phase_q;
        end
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power sequence step timer
  // ---------------------------------------------------------------
  assign seq_tick = (seq_cnt_q == SEQ_STEP - 1);

  always_ff @(posedge i_mclk) begin
    if (i_srst || seq_tick || pwr_q == PW_NORMAL || pwr_q == PW_STANDBY) begin
      seq_cnt_q <= 32'h0000_0000;
    end else begin
      seq_cnt_q <= seq_cnt_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pwr_q <= PW_UP;
      seq_q <= RANK_NONE;
    end else begin
      unique case (pwr_q)
        PW_UP: begin
          if (standby_request_pin_sync_q) begin
            pwr_q <= PW_DOWN;
          end else if (seq_tick) begin
            if (seq_q == RANK_EMMC_REGULATOR) begin
              pwr_q <= PW_NORMAL;
            end else begin
              seq_q <= seq_q + 3'h1;
            end
          end
        end
        PW_NORMAL: begin
          if (standby_request_pin_sync_q) begin
            pwr_q <= PW_DOWN;
          end
        end
        PW_DOWN: begin
          if (!standby_request_pin_sync_q) begin
            pwr_q <= PW_UP;
          end else if (seq_tick) begin
            if (seq_q == RANK_NONE) begin
              pwr_q <= PW_STANDBY;
            end else begin
              seq_q <= seq_q - 3'h1;
            end
          end
        end
        PW_STANDBY: begin
          if (!standby_request_pin_sync_q) begin
            pwr_q <= PW_UP;
          end
        end
      endcase
    end
  end

  // below the memory buck step while heading to or resting in standby
  assign low_side = (pwr_q == PW_DOWN || pwr_q == PW_STANDBY) && seq_q < RANK_MEM;
  // pull-downs read these too, so a buck never starts against its own pull-down
  assign core_en_d = enable_q[EN_CORE] && seq_q >= RANK_CORE;
  assign io_en_d = enable_q[EN_IO] && seq_q >= RANK_IO;
  assign mem_en_d = seq_q >= RANK_MEM || (low_side && ctrl_q[CTRL_MEM_STANDBY_REQUEST_PIN_KEEP]);

  // ---------------------------------------------------------------
  // regulator enables and modes
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_core_buck_en <= 1'b0;
      o_io_buck_en <= 1'b0;
      o_memory_buck_en <= 1'b0;
      o_analog_core_regulator_en <= 1'b0;
      o_emmc_regulator_en <= 1'b0;
      o_memory_buck_mode <= MODE_PWM;
      o_analog_core_regulator_from_emmc_regulator_supply_input <= 1'b0;
      o_analog_core_regulator_supply_input_stage_en <= 1'b1;
      o_standby <= 1'b0;
    end else begin
      o_core_buck_en <= core_en_d;
      o_io_buck_en <= io_en_d;
      o_memory_buck_en <= mem_en_d;
      o_analog_core_regulator_en <= (enable_q[EN_ANALOG_CORE_REGULATOR] && seq_q >= RANK_ANALOG_CORE_REGULATOR) ||
                                    (low_side && ctrl_q[CTRL_ANALOG_CORE_REGULATOR_STANDBY_REQUEST_PIN_ON]);
      o_emmc_regulator_en <= enable_q[EN_EMMC_REGULATOR] && seq_q >= RANK_EMMC_REGULATOR;
      o_memory_buck_mode <= low_side ? buck_cfg_q[CFG_MODE_LO +: 2] : MODE_PWM;
      o_analog_core_regulator_from_emmc_regulator_supply_input <= low_side;
      o_analog_core_regulator_supply_input_stage_en <= !low_side;
      o_standby <= (pwr_q == PW_STANDBY);
    end
  end

  // ---------------------------------------------------------------
  // pull-downs, phase and step size
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_pulldown_en <= '0;
      o_core_two_phase <= 1'b0;
      o_vset_step_coarse <= 1'b1;
    end else begin
      o_pulldown_en[0] <= buck_cfg_q[CFG_PD_LO] && !two_phase_q && !core_en_d;
      o_pulldown_en[1] <= buck_cfg_q[CFG_PD_LO + 1] && !io_en_d;
      o_pulldown_en[2] <= buck_cfg_q[CFG_PD_LO + 2] && !mem_en_d;
      o_core_two_phase <= two_phase_q;
      o_vset_step_coarse <= ctrl_q[CTRL_VSTEP_COARSE];
    end
  end

  // ---------------------------------------------------------------
  // serial pin and read data
  // ---------------------------------------------------------------
  assign o_sda_oe = sda_oe_q;
  assign o_sda = sda_out_q;
  assign o_rd_data = rd_data_q;

  // ---------------------------------------------------------------
  // voltage ramps, one per buck
  // ---------------------------------------------------------------
  for (genvar b = 0; b < NUM_BUCK; b++) begin : g_ramp
    volt_ramp #(
      .W(8),
      .STEP_CYC(RAMP_STEP),
      .INIT(b == 0 ? VSET_CORE_RST : (b == 1 ? VSET_IO_RST : VSET_MEM_RST))
    ) u_ramp (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_target(vset_q[b]),
      .o_level(o_buck_voltage_setting[b]),
      .o_busy(ramp_busy[b])
    );
  end

endmodule : pmu_mode_control

`default_nettype wire

// ===== dv/pmu_mode_control_monitor.sv
// assertions on the ports of the mode control block
`timescale 1ns/10ps
`default_nettype none
module pmu_mode_control_monitor
  import pmu_mode_pkg::*;
(
  // watched ports
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_standby_request_pin,
  input wire logic o_sda_oe,
  input wire logic o_core_buck_en,
  input wire logic o_io_buck_en,
  input wire logic o_memory_buck_en,
  input wire logic o_emmc_regulator_en,
  input wire logic [1:0] o_memory_buck_mode,
  input wire logic [pmu_mode_pkg::NUM_BUCK-1:0] o_pulldown_en,
  input wire logic o_analog_core_regulator_from_emmc_regulator_supply_input,
  input wire logic o_analog_core_regulator_supply_input_stage_en,
  input wire logic [pmu_mode_pkg::NUM_BUCK-1:0][7:0] o_buck_voltage_setting,
  input wire logic o_standby
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  wire logic [7:0] mem_v = o_buck_voltage_setting[2];
  sequence s_pin_up;
    $rose(i_standby_request_pin) ##0 !o_standby;
  endsequence
  sequence s_mem_move;
    !$stable(mem_v);
  endsequence
  property p_sync;
    s_pin_up |=> !o_standby [*2];
  endproperty
  a_sync: assert property (p_sync) else $error("standby ahead of pin sync");
  property p_enter;
    $rose(o_standby) |-> $past(i_standby_request_pin, 2);
  endproperty
  a_enter: assert property (p_enter) else $error("standby without pin high");
  property p_wake;
    $fell(o_standby) |-> !$past(i_standby_request_pin, 2);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without pin low");
  property p_ldo_sw;
    o_standby |-> o_analog_core_regulator_from_emmc_regulator_supply_input;
  endproperty
  a_ldo_sw: assert property (p_ldo_sw) else $error("analog_core_regulator input not switched");
  property p_stage;
    o_analog_core_regulator_supply_input_stage_en != o_analog_core_regulator_from_emmc_regulator_supply_input;
  endproperty
  a_stage: assert property (p_stage) else $error("analog_core_regulator stage overlaps switch");
  property p_normal;
    !o_standby && o_emmc_regulator_en |-> o_memory_buck_en && o_memory_buck_mode == MODE_PWM;
  endproperty
  a_normal: assert property (p_normal) else $error("memory buck not pwm in normal");
  property p_pd;
    (o_pulldown_en & {o_memory_buck_en, o_io_buck_en, o_core_buck_en}) == 3'h0;
  endproperty
  a_pd: assert property (p_pd) else $error("pull-down on a running buck");
  property p_ramp;
    s_mem_move |-> (mem_v - $past(mem_v) == 8'h01 || $past(mem_v) - mem_v == 8'h01) ##1 $stable(mem_v);
  endproperty
  a_ramp: assert property (p_ramp) else $error("voltage jumped");
  property p_ack;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_ack: assert property (p_ack) else $error("ack driven with clock high");
endmodule : pmu_mode_control_monitor
`default_nettype wire

// ===== dv/i2c_host_model.sv
// serial bus master standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
  // bus side
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic half;
    repeat (4) @(posedge i_clk);
  endtask : half
  task automatic start;
    o_sda_low <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_low <= 1'b1;
    half();
    o_scl <= 1'b0;
    half();
  endtask : start
  task automatic stop;
    o_sda_low <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_low <= 1'b0;
    half();
  endtask : stop
  task automatic pulse(input logic low, output logic seen);
    o_sda_low <= low;
    half();
    o_scl <= 1'b1;
    half();
    seen = i_sda;
    o_scl <= 1'b0;
    half();
  endtask : pulse
  // msb first, then the ninth pulse with the line released
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(!b[i], s);
    pulse(1'b0, s);
    ack = !s;
  endtask : send
endmodule : i2c_host_model
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the mode control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pmu_mode_pkg::*;
  localparam logic [7:0] DEV_W = {SLAVE_ADDR_DEF, 1'b0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic pin = 1'b0;
  logic otp_tp = 1'b0;
  logic otp_keep = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] rdat;
  logic scl, sda_low, sda_q, oe, ack, ce, ie, me, l1, l2, tp, sw, se, co, st;
  logic [1:0] md;
  logic [2:0] pd;
  logic [2:0][7:0] vs;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire logic sda = !sda_low && !(oe && !sda_q);
  always #2.5 clk = ~clk;
  i2c_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  pmu_mode_control #(.SEQ_STEP(8), .RAMP_STEP(4)) uut (
    .i_mclk(clk), .i_srst(rst), .i_addr(addr), .i_wr_data(wdat), .i_wr(wr_s), .i_rd(rd_s),
    .o_rd_data(rdat), .i_scl(scl), .i_sda(sda), .o_sda(sda_q), .o_sda_oe(oe),
    .i_otp_core_vset(8'h54), .i_otp_two_phase(otp_tp), .i_otp_mem_standby_request_pin_keep(otp_keep),
    .i_standby_request_pin(pin), .o_core_buck_en(ce), .o_io_buck_en(ie),
    .o_memory_buck_en(me), .o_analog_core_regulator_en(l1), .o_emmc_regulator_en(l2),
    .o_memory_buck_mode(md), .o_core_two_phase(tp), .o_pulldown_en(pd),
    .o_analog_core_regulator_from_emmc_regulator_supply_input(sw), .o_analog_core_regulator_supply_input_stage_en(se),
    .o_vset_step_coarse(co), .o_buck_voltage_setting(vs), .o_standby(st));
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdat, exp);
  endtask : rd
  task automatic sb(input logic [7:0] b, input logic e);
    host.send(b, ack);
    chk({7'h0, ack}, {7'h0, e});
  endtask : sb
  task automatic en(input logic [4:0] e);
    chk({3'h0, l2, l1, me, ie, ce}, {3'h0, e});
  endtask : en
  task automatic wait_std(input logic e);
    int n;
    n = 0;
    while (st !== e && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, st}, {7'h0, e});
  endtask : wait_std
  task automatic t_boot;
    repeat (60) @(posedge clk);
    #1 en(5'h1d);
    chk({4'h0, md, tp, co}, {4'h0, MODE_PWM, 2'h1});
    chk(vs[0], 8'h54);
    rd(REG_CTRL, CTRL_RST);
    rd(REG_VSET_IO, 8'h50);
    rd(REG_VSET_MEM, 8'h78);
    rd(REG_VSET_CORE, 8'h54);
    rd(8'h07, 8'h00);
  endtask : t_boot
  task automatic t_repeat;
    wr(REG_CTRL, 8'h09);
    host.start();
    sb(DEV_W, 1'b1);
    sb(REG_VSET_IO, 1'b1);
    sb(8'h60, 1'b1);
    sb(REG_ENABLE, 1'b1);
    sb(8'h0f, 1'b1);
    host.stop();
    rd(REG_VSET_IO, 8'h60);
    rd(REG_ENABLE, 8'h0f);
    en(5'h1f);
    wr(REG_VSET_MEM, 8'h7c);
    #1 chk({7'h0, vs[2] < 8'h7c}, 8'h01);
    repeat (40) @(posedge clk);
    #1 chk(vs[2], 8'h7c);
  endtask : t_repeat
  task automatic t_abort;
    host.start();
    sb(DEV_W, 1'b1);
    sb(REG_VSET_MEM, 1'b1);
    host.start();
    sb(8'h80, 1'b0);
    sb(8'h11, 1'b0);
    host.stop();
    rd(REG_VSET_MEM, 8'h7c);
  endtask : t_abort
  task automatic t_standby_request_pin(input logic k, input logic [1:0] m);
    wr(REG_CTRL, {4'h0, !k, k, k, 1'b0});
    wr(REG_BUCK_CFG, {6'h06, m});
    @(posedge clk);
    pin <= 1'b1;
    wait_std(1'b1);
    repeat (4) @(posedge clk);
    #1 en({1'b0, k, k, 2'b00});
    chk({2'h0, co, sw, se, pd}, {2'h0, !k, 2'b10, !k, 2'b10});
    if (k)
      chk({6'h0, md}, {6'h0, m});
    host.start();
    sb(DEV_W, 1'b1);
    sb(REG_VSET_IO, 1'b1);
    sb({6'h19, m}, 1'b1);
    host.stop();
    @(posedge clk);
    pin <= 1'b0;
    wait_std(1'b0);
    repeat (60) @(posedge clk);
    #1 en(5'h1f);
    chk({4'h0, md, sw, se}, {4'h0, MODE_PWM, 2'b01});
    rd(REG_VSET_IO, {6'h19, m});
  endtask : t_standby_request_pin
  task automatic t_otp;
    @(posedge clk);
    rst <= 1'b1;
    otp_tp <= 1'b1;
    otp_keep <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    rd(REG_CTRL, 8'h0a);
    rd(REG_STATUS, 8'h10);
    wr(REG_BUCK_CFG, 8'h06);
    wr(REG_ENABLE, 8'h0c);
    repeat (3) @(posedge clk);
    #1 chk({5'h0, tp, pd[0], ce}, 8'h04);
  endtask : t_otp
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_boot();
    t_repeat();
    t_abort();
    t_standby_request_pin(1'b0, MODE_PFM);
    t_standby_request_pin(1'b1, MODE_PFM);
    t_standby_request_pin(1'b1, MODE_AUTO);
    t_standby_request_pin(1'b1, MODE_PWM);
    t_otp();
    test_done();
  end
endmodule : testbench
bind pmu_mode_control pmu_mode_control_monitor mon (.i_mclk, .i_srst, .i_scl,
  .i_standby_request_pin, .o_sda_oe, .o_core_buck_en, .o_io_buck_en, .o_memory_buck_en,
  .o_emmc_regulator_en, .o_memory_buck_mode, .o_pulldown_en, .o_analog_core_regulator_from_emmc_regulator_supply_input,
  .o_analog_core_regulator_supply_input_stage_en, .o_buck_voltage_setting, .o_standby);
`default_nettype wire
